// [stme_exec.v]
// Execution of subroutine, timer, standby, status-test and carry instructions
`timescale 1ns/100ps
`include "stme_defs.vh"
module stme_exec (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Decode port
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [9:0] op_word2,
  input wire [9:0] pc_now,
  input wire [3:0] acc_in,
  input wire [3:0] low_bank_register,
  input wire prescale_slow,
  // Indirect fetch
  input wire [1:0] rom_page_control,
  input wire [7:0] rom_pointer_pair,
  input wire [9:0] rom_data,
  // Status pins, asynchronous
  input wire sense_input,
  input wire sense_led_line,
  input wire key_io_lines,
  input wire key_input_lines,
  // Results
  output reg [9:0] pc_q,
  output reg pc_load_q,
  output reg [3:0] acc_q,
  output reg acc_load_q,
  output reg carry_flag_q,
  output reg test_flag_q,
  output reg [9:0] timer_reload_value_q,
  output reg [9:0] rom_addr_q,
  output reg standby_q,
  output reg [3:0] wake_cond_q,
  output reg stack_index_q,
  output reg internal_reset_q,
  output reg busy_q,
  output reg timer_status_q
);
  // ---------------------------------------------------------------
  // Overview
  // ---------------------------------------------------------------
  // The core hands over one decoded instruction at a time on op_valid.
  // Most instructions finish at the next edge; a call, an indirect timer
  // load and an internal reset occupy the sequencer for extra cycles and
  // hold busy_q high meanwhile. The core must wait for busy_q to fall,
  // because a request made while busy is dropped without any trace.
  // Results leave through registers only, so every output is at least one edge
  // behind the request that caused it.
  // Limitation: there is a single return level, so the core cannot nest
  // subroutines; a second call without a return restarts program flow.

  // ---------------------------------------------------------------
  // Local state
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CALL2 = 2'h1;
  localparam ST_IND = 2'h2;
  localparam ST_IRST = 2'h3;

  reg [1:0] state_q; // Sequencer state
  reg [9:0] return_address_store_q; // One-level address stack
  reg [9:0] call_tgt_q; // Target held across call cycles
  reg [2:0] irst_cnt_q; // Internal reset pulse counter
  reg [3:0] s1_q; // First synchroniser stage
  reg [3:0] s2_q; // Second synchroniser stage
  wire expired; // Timer interval reached
  reg timer_load_q; // Reload strobe to tick counter

  // ---------------------------------------------------------------
  // Status synchronisers
  // ---------------------------------------------------------------
  // Pins are asynchronous, so two flops before the compare.
  // Only the second stage is read by logic; the first stage may still be
  // settling from a metastable sample and must never fan out.
  // The cost is two cycles of latency on every pin, which a status test
  // sees as the pin level from two edges earlier.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end else begin
      s1_q <= {sense_input, sense_led_line, key_io_lines, key_input_lines};
      s2_q <= s1_q;
    end
  end

  // Status order: bit3 sense, bit2 key io, bit1 key in, bit0 timer
  // Both sense pins share bit 3, so a mask bit there watches either pin.
  // The timer bit is the tick counter's own flop, already on this clock.
  wire [3:0] status_vec = {s2_q[3] | s2_q[2], s2_q[1], s2_q[0], expired};
  // Second words carry their fields in a scrambled order; undo it here
  // so the sequencer only ever handles plain binary values.
  // Carry-on-all-ones keeps the low run of ones: adding one turns that run
  // into zeros and the first zero into a one, so the inverse masks it.
  wire [9:0] call_dec = {op_word2[9], op_word2[4], op_word2[8:5], op_word2[3:0]};
  wire [9:0] timm_dec = {op_word2[8:5], op_word2[3:0], op_word2[9], op_word2[4]};
  wire [3:0] carry_on_all_ones_op_val = ~(acc_in + 4'h1) & acc_in;

  // ---------------------------------------------------------------
  // Timer tick counter
  // ---------------------------------------------------------------
  // The counter restarts on every reload strobe and holds its expired
  // flag until the next one, so a status test after expiry stays true.
  stme_tick u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(timer_load_q),
    .value(timer_reload_value_q),
    .slow(prescale_slow),
    .expired_q(expired)
  );

  // Reload strobe follows any timer write by one cycle.
  // The delay lets the tick counter see the value already written into
  // the reload register, so no bypass of the new value is needed; the
  // price is one extra clock before the interval starts counting.
  // An indirect load strobes from its memory cycle, when the word lands.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_load_q <= 1'b0;
    end else begin
      timer_load_q <= op_valid && state_q == ST_IDLE &&
        (op_code == `STME_OP_WR_T1 || op_code == `STME_OP_WR_T0 ||
         op_code == `STME_OP_LD_TIMM) || state_q == ST_IND;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and datapath
  // ---------------------------------------------------------------
  // Requests arriving while busy are ignored; the core waits on busy_q
  // Pulses (pc_load_q, acc_load_q) drop by default at every edge and are
  // raised only in the branch that produces a new value, so each one
  // stands for exactly one cycle.
  // The stack pointer is a single bit: one means a return address is held.
  // Its carry on a second call and its borrow on a lone return both lead
  // to the internal reset state instead of corrupting the saved address.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      return_address_store_q <= `STME_PC_RST;
      call_tgt_q <= `STME_PC_RST;
      irst_cnt_q <= 3'h0;
      pc_q <= `STME_PC_RST;
      pc_load_q <= 1'b0;
      acc_q <= 4'h0;
      acc_load_q <= 1'b0;
      carry_flag_q <= 1'b0;
      test_flag_q <= 1'b0;
      timer_reload_value_q <= `STME_TIMER_RST;
      rom_addr_q <= 10'h000;
      standby_q <= 1'b0;
      wake_cond_q <= 4'h0;
      stack_index_q <= `STME_SP_RST;
      internal_reset_q <= 1'b0;
      busy_q <= 1'b0;
      timer_status_q <= 1'b0;
    end else begin
      pc_load_q <= 1'b0;
      acc_load_q <= 1'b0;
      timer_status_q <= expired;
      case (state_q)
        ST_IDLE: begin
          busy_q <= 1'b0;
          if (op_valid) begin
            standby_q <= 1'b0;
            case (op_code)
              `STME_OP_CALL: begin
                if (stack_index_q == 1'b1) begin
                  state_q <= ST_IRST;
                  internal_reset_q <= 1'b1;
                  irst_cnt_q <= `STME_IRST_CYCLES;
                  busy_q <= 1'b1;
                end else begin
                  // First cycle: bump the pointer and save the return point
                  stack_index_q <= 1'b1;
                  return_address_store_q <= pc_now;
                  call_tgt_q <= call_dec;
                  state_q <= ST_CALL2;
                  busy_q <= 1'b1;
                end
              end
              `STME_OP_RET: begin
                if (stack_index_q == 1'b0) begin
                  state_q <= ST_IRST;
                  internal_reset_q <= 1'b1;
                  irst_cnt_q <= `STME_IRST_CYCLES;
                  busy_q <= 1'b1;
                end else begin
                  // Single cycle: jump back, then release the stack level
                  pc_q <= return_address_store_q;
                  pc_load_q <= 1'b1;
                  stack_index_q <= 1'b0;
                end
              end
              `STME_OP_RD_T1: begin
                acc_q <= timer_reload_value_q[9:6];
                acc_load_q <= 1'b1;
              end
              `STME_OP_RD_T0: begin
                acc_q <= timer_reload_value_q[5:2];
                acc_load_q <= 1'b1;
              end
              // Nibble writes clear the spare low bit of their half
              `STME_OP_WR_T1: begin
                timer_reload_value_q[9:6] <= acc_in;
                timer_reload_value_q[1] <= 1'b0;
              end
              `STME_OP_WR_T0: begin
                timer_reload_value_q[5:2] <= acc_in;
                timer_reload_value_q[0] <= 1'b0;
              end
              `STME_OP_LD_TIMM: begin
                timer_reload_value_q <= timm_dec;
              end
              // Page bits form the top of the fetch address, the pointer the rest
              `STME_OP_LD_TIND: begin
                rom_addr_q <= {rom_page_control, rom_pointer_pair};
                state_q <= ST_IND;
                busy_q <= 1'b1;
              end
              // Standby level drops again with the next request of any kind other than another halt
              `STME_OP_HALT: begin
                standby_q <= 1'b1;
                wake_cond_q <= op_word2[3:0];
              end
              // A status test raises the flag if any enabled status is high
              // and clears it otherwise, so the flag never keeps old results
              `STME_OP_STATUS_TEST_OP_REG: begin
                test_flag_q <= |(status_vec & low_bank_register);
              end
              `STME_OP_STATUS_TEST_OP_IMM: begin
                test_flag_q <= |(status_vec & op_word2[3:0]);
              end
              // Carry reports a full accumulator; the value keeps its low
              // run of ones and clears every bit above the first zero
              `STME_OP_CARRY_ON_ALL_ONES_OP: begin
                carry_flag_q <= (acc_in == `STME_ALL_ONES);
                acc_q <= carry_on_all_ones_op_val;
                acc_load_q <= 1'b1;
              end
              default: begin
                // No operation: program counter advance is the core's job
              end
            endcase
          end
        end
        ST_CALL2: begin
          // Second cycle: the decoded target enters the program counter
          pc_q <= call_tgt_q;
          pc_load_q <= 1'b1;
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
        ST_IND: begin
          // Memory answers one cycle after the address is presented
          // The core must keep rom_data stable while busy_q is high
          timer_reload_value_q <= rom_data;
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
        ST_IRST: begin
          // Internal reset returns the stack and PC to their reset state
          // Timer, flags and accumulator are left alone: only program flow
          // restarts, and the core sees the restart through pc_load_q in the
          // cycle right after the pulse ends.
          stack_index_q <= `STME_SP_RST;
          pc_q <= `STME_PC_RST;
          standby_q <= 1'b0;
          if (irst_cnt_q == 3'h1) begin
            internal_reset_q <= 1'b0;
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            pc_load_q <= 1'b1;
          end
          irst_cnt_q <= irst_cnt_q - 3'h1;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// [stme_defs.vh]
// Opcodes, reset values and timing constants for the execution block
`ifndef STME_DEFS_VH
`define STME_DEFS_VH

// ---------------------------------------------------------------
// Opcode classes presented on the decode port
// ---------------------------------------------------------------
`define STME_OP_NOP 4'h0
`define STME_OP_CALL 4'h1
`define STME_OP_RET 4'h2
`define STME_OP_RD_T1 4'h3
`define STME_OP_RD_T0 4'h4
`define STME_OP_WR_T1 4'h5
`define STME_OP_WR_T0 4'h6
`define STME_OP_LD_TIMM 4'h7
`define STME_OP_LD_TIND 4'h8
`define STME_OP_HALT 4'h9
`define STME_OP_STATUS_TEST_OP_REG 4'ha
`define STME_OP_STATUS_TEST_OP_IMM 4'hb
`define STME_OP_CARRY_ON_ALL_ONES_OP 4'hc

// ---------------------------------------------------------------
// Reset values and widths
// ---------------------------------------------------------------
`define STME_PC_RST 10'h000
`define STME_TIMER_RST 10'h000
`define STME_SP_RST 1'b0
`define STME_ALL_ONES 4'hf

// ---------------------------------------------------------------
// Timer tick
// ---------------------------------------------------------------
`define STME_TICK_SLOW 5'h10
`define STME_TICK_FAST 5'h08
// Internal reset pulse length, in cycles
`define STME_IRST_CYCLES 3'h2

`endif

// [stme_tick.v]
// Prescaled timer counter: interval is (value + 1) times 8 or 16 clocks
`timescale 1ns/100ps
`include "stme_defs.vh"
module stme_tick (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Control
  input wire load,
  input wire [9:0] value,
  input wire slow,
  // Status
  output reg expired_q
);
  reg [4:0] pre_q; // Prescale counter
  reg [9:0] cnt_q; // Interval counter
  reg run_q; // Counting in progress
  wire [4:0] pre_top = slow ? `STME_TICK_SLOW : `STME_TICK_FAST;

  // Count down value+1 prescaled periods after each load
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 5'h00;
      cnt_q <= 10'h000;
      run_q <= 1'b0;
      expired_q <= 1'b0;
    end else if (load) begin
      pre_q <= 5'h00;
      cnt_q <= value;
      run_q <= 1'b1;
      expired_q <= 1'b0;
    end else if (run_q) begin
      if (pre_q == pre_top - 5'h01) begin
        pre_q <= 5'h00;
        if (cnt_q == 10'h000) begin
          run_q <= 1'b0;
          expired_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 10'h001;
        end
      end else begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end
endmodule

// [stme_exec_sva.sv]
// Checker for the execution block
`timescale 1ns/100ps
`include "stme_defs.vh"
module stme_exec_sva (
  // Clock, reset and decode port
  input wire sys_clk,
  input wire rst_n,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [9:0] op_word2,
  input wire [9:0] pc_now,
  input wire [3:0] acc_in,
  input wire [1:0] rom_page_control,
  input wire [7:0] rom_pointer_pair,
  input wire [9:0] rom_data,
  // Results
  input wire [9:0] pc_q,
  input wire pc_load_q,
  input wire [3:0] acc_q,
  input wire carry_flag_q,
  input wire [9:0] timer_reload_value_q,
  input wire [9:0] rom_addr_q,
  input wire standby_q,
  input wire [3:0] wake_cond_q,
  input wire stack_index_q,
  input wire internal_reset_q,
  input wire busy_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Requests count only while idle
  wire tk = op_valid && !busy_q;
  wire [9:0] w = op_word2;
  wire [9:0] t = timer_reload_value_q;
  reg [9:0] ret_q; // Address saved by the last call
  reg [9:0] tg_q; // Target of the last call
  always @(posedge sys_clk) begin
    if (tk && op_code == `STME_OP_CALL) begin
      ret_q <= pc_now;
      tg_q <= {w[9], w[4], w[8:5], w[3:0]};
    end
  end
  sequence s_call;
    tk && op_code == `STME_OP_CALL && !stack_index_q;
  endsequence
  sequence s_jump;
    stack_index_q && busy_q ##1 pc_load_q && pc_q == tg_q;
  endsequence
  AST_CALL: assert property (s_call |=> s_jump)
    else $error("call did not jump to target");
  AST_NEST: assert property (tk && op_code == `STME_OP_CALL && stack_index_q
    |=> internal_reset_q [*2] ##1 pc_load_q && pc_q == `STME_PC_RST)
    else $error("nested call did not reset");
  AST_RET: assert property (tk && op_code == `STME_OP_RET && stack_index_q
    |=> pc_load_q && pc_q == ret_q && !stack_index_q)
    else $error("return did not restore address");
  AST_UNDER: assert property (tk && op_code == `STME_OP_RET && !stack_index_q
    |=> internal_reset_q)
    else $error("return underflow did not reset");
  AST_RD: assert property (tk && op_code == `STME_OP_RD_T1 |=> acc_q == $past(t[9:6]))
    else $error("timer high read wrong");
  AST_WR: assert property (tk && op_code == `STME_OP_WR_T1
    |=> t == {$past(acc_in), $past(t[5:2]), 1'b0, $past(t[0])})
    else $error("timer high write wrong");
  AST_IMM: assert property (tk && op_code == `STME_OP_LD_TIMM
    |=> t == {$past(w[8:5]), $past(w[3:0]), $past(w[9]), $past(w[4])})
    else $error("immediate timer load wrong");
  AST_IND: assert property (tk && op_code == `STME_OP_LD_TIND
    |=> rom_addr_q == {$past(rom_page_control), $past(rom_pointer_pair)}
    ##1 t == $past(rom_data))
    else $error("indirect timer load wrong");
  AST_HALT: assert property (tk && op_code == `STME_OP_HALT
    |=> standby_q && wake_cond_q == $past(w[3:0]))
    else $error("standby entry wrong");
  AST_CARRY_ON_ALL_ONES_OP: assert property (tk && op_code == `STME_OP_CARRY_ON_ALL_ONES_OP
    |=> carry_flag_q == ($past(acc_in) == `STME_ALL_ONES)
    && acc_q == ($past(acc_in) & ~($past(acc_in) + 4'h1)))
    else $error("carry on all ones wrong");
endmodule
bind stme_exec stme_exec_sva i_stme_exec_sva (.*);

// [testbench.sv]
// Self-checking bench for the execution block
`timescale 1ns/100ps
`include "stme_defs.vh"
module testbench;
  reg sys_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, prescale_slow = 1'b0;
  reg sense_input = 1'b0, sense_led_line = 1'b0, key_io_lines = 1'b0;
  reg key_input_lines = 1'b0;
  reg [3:0] op_code = 4'h0, acc_in = 4'h0, low_bank_register = 4'h0;
  reg [9:0] op_word2 = 10'h000, pc_now = 10'h000, rom_data = 10'h000;
  reg [1:0] rom_page_control = 2'h0;
  reg [7:0] rom_pointer_pair = 8'h00;
  wire [9:0] pc_q, timer_reload_value_q, rom_addr_q;
  wire [3:0] acc_q, wake_cond_q;
  wire pc_load_q, acc_load_q, carry_flag_q, test_flag_q, standby_q;
  wire stack_index_q, internal_reset_q, busy_q, timer_status_q;
  integer i, k, n_fail = 0, n_checks = 0, cyc = 0;
  reg [31:0] seed = 32'd44;
  reg [9:0] w, sv, tm;
  reg [3:0] a, st;
  stme_exec i_stme_exec (.*);
  // Free-running clock
  initial forever #20 sys_clk = ~sys_clk;
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // Call target and timer word from their scrambled second words
  function [9:0] tgt(input [9:0] x);
    tgt = {x[9], x[4], x[8:5], x[3:0]};
  endfunction
  function [9:0] imm(input [9:0] x);
    imm = {x[8:5], x[3:0], x[9], x[4]};
  endfunction
  // Clocks from the write to the status rise: reload and status add one each
  function integer ticks(input [9:0] v, input s);
    ticks = (v + 1) * (s ? `STME_TICK_SLOW : `STME_TICK_FAST) + 2;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // One op: side inputs drawn afresh; status pins move only on NOP so sync can settle
  task op(input [3:0] c, input [9:0] x, input [3:0] y, input integer n);
    begin
      @(posedge sys_clk);
      seed = xs(seed);
      op_code <= c;
      op_word2 <= x;
      acc_in <= y;
      op_valid <= 1'b1;
      pc_now <= seed[9:0];
      {rom_page_control, rom_pointer_pair} <= seed[19:10];
      low_bank_register <= seed[23:20];
      prescale_slow <= seed[23];
      rom_data <= seed[31:22];
      if (c == `STME_OP_NOP) begin
        {sense_input, sense_led_line, key_io_lines, key_input_lines} <= seed[27:24];
      end
      @(posedge sys_clk);
      op_valid <= 1'b0;
      // n counts edges from taking to the result, the taking edge included
      repeat (n - 1) @(posedge sys_clk);
      #1;
    end
  endtask
  // Timer interval from a small immediate load, counted in clocks
  task tmr(input [9:0] x);
    begin
      op(`STME_OP_LD_TIMM, x, 4'h0, 1);
      k = 0;
      // Skip the two edges in which an older expiry may still show
      while ((k < 3 || timer_status_q !== 1'b1) && k < 600) begin
        @(posedge sys_clk);
        #1;
        k = k + 1;
      end
      chk(k, ticks(imm(x), prescale_slow));
    end
  endtask
  // Hang guard: the whole loop needs well under this many clocks
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({pc_q, stack_index_q, timer_reload_value_q}, 21'h0);
    op(`STME_OP_RET, 10'h000, 4'h0, 1);
    chk(internal_reset_q, 1'b1);
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      w = seed[9:0];
      a = seed[13:10];
      op(`STME_OP_CALL, w, a, 2);
      chk({pc_load_q, stack_index_q, busy_q, pc_q}, {3'b110, tgt(w)});
      sv = pc_now;
      if (i[0]) begin
        op(`STME_OP_CALL, w, a, 1);
        chk(internal_reset_q, 1'b1);
        repeat (3) @(posedge sys_clk);
      end else begin
        op(`STME_OP_RET, w, a, 1);
        chk({pc_load_q, stack_index_q, pc_q}, {2'b10, sv});
      end
      op(`STME_OP_LD_TIMM, w, a, 1);
      tm = imm(w);
      chk(timer_reload_value_q, tm);
      op(`STME_OP_RD_T1, w, a, 1);
      chk({acc_load_q, acc_q}, {1'b1, tm[9:6]});
      op(`STME_OP_RD_T0, w, a, 1);
      chk(acc_q, tm[5:2]);
      op(`STME_OP_WR_T1, w, a, 1);
      tm = {a, tm[5:2], 1'b0, tm[0]};
      chk(timer_reload_value_q, tm);
      op(`STME_OP_WR_T0, w, ~a, 1);
      tm = {tm[9:6], ~a, tm[1], 1'b0};
      chk(timer_reload_value_q, tm);
      op(`STME_OP_LD_TIND, w, a, 2);
      chk({rom_addr_q, timer_reload_value_q},
          {rom_page_control, rom_pointer_pair, rom_data});
      op(`STME_OP_HALT, w, a, 1);
      chk({standby_q, wake_cond_q}, {1'b1, w[3:0]});
      op(`STME_OP_CARRY_ON_ALL_ONES_OP, w, i[3:0], 1);
      chk({carry_flag_q, acc_q}, {i[3:0] == 4'hf, i[3:0] & ~(i[3:0] + 4'h1)});
      tmr({w[9], 4'h0, w[4], 2'h0, w[1:0]});
      op(`STME_OP_NOP, w, a, 3);
      // The timer has just expired and stays so until the next reload
      st = {sense_input | sense_led_line, key_io_lines, key_input_lines, 1'b1};
      op(`STME_OP_STATUS_TEST_OP_IMM, {6'h00, w[3:0]}, a, 1);
      chk(test_flag_q, |(st & w[3:0]));
      op(`STME_OP_STATUS_TEST_OP_REG, w, a, 1);
      chk(test_flag_q, |(st & low_bank_register));
    end
    complete_run;
  end
endmodule
